// File: logic/watchdog_reset_timer.v
// Watchdog timer with reset-source tracking and boot area selection.
// Assumes nrst is the system reset, fed back from reset_request among others, and that
// power_on_rst is a synchronous power-on indication that outlasts nrst.
`timescale 1ns/10ps
`include "watchdog_reset_timer_consts.vh"

module watchdog_reset_timer (
  input wire sys_clk,
  input wire nrst,
  input wire power_on_rst,
  input wire idle_mode,
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire [7:0] sfr_wdata,
  output reg [7:0] sfr_rdata,
  output reg reset_request,
  output reg boot_from_loader
);

  reg run_q;
  reg idle_cnt_q;
  reg [2:0] ps_sel_q;
  reg flag_q;
  reg [3:0] div12_q;
  reg [`PRESCALE_WIDTH-1:0] presc_q;
  reg [`COUNTER_WIDTH-1:0] count_q;
  reg boot_sel_q;
  reg [1:0] src_state_q;
  reg [1:0] src_state_d;
  reg [7:0] rdata_d;
  wire [`PRESCALE_WIDTH-1:0] presc_last;
  wire [`PRESCALE_WIDTH-1:0] presc_last_tab [0:7];

  // Reset source states: was the system reset now under way asked for by this block?
  localparam ST_NORMAL = 2'h0;
  localparam ST_REQUESTED = 2'h1;
  localparam ST_OWN_RESET = 2'h2;
  localparam ST_PIN_RESET = 2'h3;

  wire own_reset = (src_state_q == ST_REQUESTED) || (src_state_q == ST_OWN_RESET);

  wire wdc_wr = sfr_wr && (sfr_addr == `WATCHDOG_CONTROL_ADDR);
  wire boot_wr = sfr_wr && (sfr_addr == `BOOT_CONTROL_ADDR);
  wire restart = wdc_wr && sfr_wdata[`WDC_RESTART_BIT];
  wire soft_reset = boot_wr && sfr_wdata[`BOOT_SOFT_RESET_BIT];
  wire counting = run_q && !(idle_mode && !idle_cnt_q);
  wire div_tick = counting && (div12_q == `CLK_DIV_LAST);
  wire presc_tick = div_tick && (presc_q == presc_last);
  wire overflow = presc_tick && (count_q == `COUNTER_LAST);

  // prescale decode
  // One terminal count per select code, so the compare path sees a plain table look-up.
  genvar k;
  generate
    for (k = 0; k < 8; k = k + 1) begin : g_presc_code
      assign presc_last_tab[k] = (8'h02 << k) - 8'h01;
    end
  endgenerate

  assign presc_last = presc_last_tab[ps_sel_q];

  always @(posedge sys_clk) begin
    if (!nrst) begin
      div12_q <= 4'h0;
      presc_q <= 8'h00;
      count_q <= 15'h0000;
    end else if (restart) begin
      div12_q <= 4'h0;
      presc_q <= 8'h00;
      count_q <= 15'h0000;
    end else if (counting) begin
      div12_q <= div_tick ? 4'h0 : div12_q + 4'h1;
      if (div_tick) begin
        presc_q <= presc_tick ? 8'h00 : presc_q + 8'h01;
      end
      if (presc_tick) begin
        count_q <= count_q + 15'h0001;
      end
    end
  end

  always @(posedge sys_clk) begin
    if (!nrst) begin
      run_q <= 1'b0;
      idle_cnt_q <= 1'b0;
      ps_sel_q <= 3'h0;
    end else if (wdc_wr) begin
      run_q <= sfr_wdata[`WDC_RUN_BIT];
      idle_cnt_q <= sfr_wdata[`WDC_IDLE_BIT];
      ps_sel_q <= sfr_wdata[`WDC_PS_MSB:`WDC_PS_LSB];
    end
  end

  // sticky flag; only power-on clears it besides software, and a set wins over a software clear.
  always @(posedge sys_clk) begin
    if (power_on_rst) begin
      flag_q <= 1'b0;
    end else if (overflow) begin
      flag_q <= 1'b1;
    end else if (wdc_wr && !sfr_wdata[`WDC_FLAG_BIT]) begin
      flag_q <= 1'b0;
    end
  end

  // reset on overflow, soft reset pulse
  always @(posedge sys_clk) begin
    if (!nrst) begin
      reset_request <= 1'b0;
    end else begin
      reset_request <= overflow || soft_reset;
    end
  end

  // The request is held until nrst has gone low and risen again, so the outside reset logic may take
  // any number of cycles to act. A request that never turns into a reset makes the next pin reset
  // count as this block's own; the two cannot be told apart at the ports.
  always @* begin
    src_state_d = src_state_q;
    case (src_state_q)
      ST_NORMAL: begin
        if (!nrst) begin
          src_state_d = ST_PIN_RESET;
        end else if (overflow || soft_reset) begin
          src_state_d = ST_REQUESTED;
        end
      end
      ST_REQUESTED: begin
        if (!nrst) begin
          src_state_d = ST_OWN_RESET;
        end
      end
      ST_OWN_RESET, ST_PIN_RESET: begin
        // A request on the first edge after reset must not be lost.
        if (nrst) begin
          src_state_d = (overflow || soft_reset) ? ST_REQUESTED : ST_NORMAL;
        end
      end
      default: begin
        src_state_d = ST_NORMAL;
      end
    endcase
  end

  // Boot selection survives system reset so the area chosen before a soft reset is honoured after it.
  always @(posedge sys_clk) begin
    if (power_on_rst) begin
      boot_sel_q <= 1'b1;
      src_state_q <= ST_NORMAL;
      boot_from_loader <= 1'b1;
    end else begin
      src_state_q <= src_state_d;
      if (boot_wr) begin
        boot_sel_q <= sfr_wdata[`BOOT_AREA_BIT];
      end
      if (overflow) begin
        boot_sel_q <= 1'b0;
      end
      if (!nrst) begin
        // area select, loader on 60H, pin reset to application
        boot_from_loader <= own_reset ? boot_sel_q : 1'b0;
      end
    end
  end

  // bit 6 reads zero; restart and trigger read zero.
  wire [7:0] wdc_read = {flag_q, 1'b0, run_q, 1'b0, idle_cnt_q, ps_sel_q};
  wire [7:0] boot_read = {1'b0, boot_sel_q, 6'h00};

  always @* begin
    case (sfr_addr)
      `WATCHDOG_CONTROL_ADDR: begin
        rdata_d = wdc_read;
      end
      `BOOT_CONTROL_ADDR: begin
        rdata_d = boot_read;
      end
      default: begin
        rdata_d = 8'h00;
      end
    endcase
  end

  // Registered read data keeps the register port free of a combinational path through the decode.
  always @(posedge sys_clk) begin
    if (!nrst) begin
      sfr_rdata <= 8'h00;
    end else begin
      sfr_rdata <= rdata_d;
    end
  end

endmodule // watchdog_reset_timer

// File: logic/watchdog_reset_timer_consts.vh
// Constants for the watchdog and reset-source block: register addresses, fields and counts.
// Assumes an 8-bit special function register port driven by the CPU on the system clock.
`ifndef WATCHDOG_RESET_TIMER_CONSTS_VH
`define WATCHDOG_RESET_TIMER_CONSTS_VH

`define WATCHDOG_CONTROL_ADDR 8'he1
`define BOOT_CONTROL_ADDR 8'he7

`define WDC_FLAG_BIT 7
`define WDC_RUN_BIT 5
`define WDC_RESTART_BIT 4
`define WDC_IDLE_BIT 3
`define WDC_PS_MSB 2
`define WDC_PS_LSB 0

`define BOOT_AREA_BIT 6
`define BOOT_SOFT_RESET_BIT 5

`define CLK_DIV_LAST 4'hb
`define PRESCALE_WIDTH 8
`define COUNTER_WIDTH 15
`define COUNTER_LAST 15'h7fff

`endif

// File: tb/wdt_chk_asserts.sv
// Assertions on the watchdog register port and reset outputs.
// Bound to every watchdog_reset_timer instance.
`timescale 1ns/10ps
module wdt_chk (
  input wire sys_clk,
  input wire nrst,
  input wire power_on_rst,
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire [7:0] sfr_wdata,
  input wire [7:0] sfr_rdata,
  input wire reset_request,
  input wire boot_from_loader
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst || power_on_rst);
  sequence soft_wr; sfr_wr && sfr_addr == 8'he7 && sfr_wdata[5]; endsequence
  sequence ctl_wr; sfr_wr && sfr_addr == 8'he1 ##1 sfr_addr == 8'he1; endsequence
  a_soft_reset_pulse: assert property (soft_wr |=> reset_request ##1 !reset_request)
    else $error("no pulse");
  a_request_single: assert property (reset_request |=> !reset_request) else $error("long");
  a_spare_bit_zero: assert property ($past(sfr_addr) == 8'he1 |-> !sfr_rdata[6]) else $error("b6");
  a_restart_self_clear: assert property ($past(sfr_addr) == 8'he1 |-> !sfr_rdata[4]) else $error("b4");
  a_trigger_self_clear: assert property ($past(sfr_addr) == 8'he7 |-> !sfr_rdata[5]) else $error("b5");
  a_unmapped_read_zero: assert property (!($past(sfr_addr) inside {8'he1, 8'he7}) |-> sfr_rdata == 8'h00)
    else $error("unmapped");
  a_fields_follow: assert property (ctl_wr |=> (sfr_rdata & 8'h2f) == ($past(sfr_wdata, 2) & 8'h2f))
    else $error("fields");
  a_power_on_loader: assert property (disable iff (1'b0) power_on_rst |=> boot_from_loader)
    else $error("boot");
endmodule // wdt_chk
bind watchdog_reset_timer wdt_chk wdt_chk_i (.*);

// File: tb/tb.sv
// Bench: register reads, soft and pin resets, boot area.
// The bench plays the system that turns a reset request into nrst.
`timescale 1ns/10ps
module tb;
  reg sys_clk = 1'h0, nrst = 1'h0, power_on_rst = 1'h1, idle_mode = 1'h0, sfr_wr = 1'h0;
  reg [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, d;
  wire [7:0] sfr_rdata;
  wire reset_request, boot_from_loader;
  integer num_errors = 0, checked = 0, i, m;
  watchdog_reset_timer watchdog_reset_timer_i (.*);
  initial forever #2.5 sys_clk = ~sys_clk;
  task cmp(input [15:0] got, exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task wr(input [7:0] a, v);
    @(posedge sys_clk);
    sfr_wr <= 1'h1;
    sfr_addr <= a;
    sfr_wdata <= v;
    @(posedge sys_clk);
    sfr_wr <= 1'h0;
    #1;
  endtask
  task rd(input [7:0] a, exp);
    @(posedge sys_clk);
    sfr_addr <= a;
    @(posedge sys_clk);
    #1 cmp(sfr_rdata, exp);
  endtask
  // Model of the divider chain: n counted clocks, twelve per step, 2 << ps steps per count.
  task chk_count(input integer n, ps, input paused);
    integer cyc, fac;
    begin
      cyc = paused ? 0 : n;
      fac = 2 << ps;
      cmp(watchdog_reset_timer_i.div12_q, cyc % 12);
      cmp(watchdog_reset_timer_i.presc_q, (cyc / 12) % fac);
      cmp(watchdog_reset_timer_i.count_q, cyc / (12 * fac));
    end
  endtask
  task end_sim;
    $display("checked %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #60000 num_errors++;
    end_sim;
  end
  initial begin
    void'($urandom(32'h3068));
    repeat (6) @(posedge sys_clk);
    nrst <= 1'h1;
    power_on_rst <= 1'h0;
    #1 cmp(boot_from_loader, 8'h01);
    for (i = 0; i < 24; i++) begin
      d = $urandom;
      idle_mode <= d[6];
      wr(8'he1, d);
      rd(8'he1, {2'h0, d[5], 1'h0, d[3:0]});
      rd({1'h0, d[6:0]}, 8'h00);
    end
    $display("register test done");
    // Each pass restarts with one select code, runs a random span, halts and checks the count holds.
    for (i = 0; i < 8; i++) begin
      d = $urandom;
      m = 300 + d[6:0];
      idle_mode <= d[7];
      wr(8'he1, {2'h0, 1'h1, 1'h1, d[6], i[2:0]});
      repeat (m) @(posedge sys_clk);
      #1 chk_count(m, i, d[7] && !d[6]);
      wr(8'he1, 8'h00);
      repeat (40) @(posedge sys_clk);
      #1 chk_count(m + 2, i, d[7] && !d[6]);
    end
    idle_mode <= 1'h0;
    $display("count test done");
    // Each pass picks a boot area and either a soft or a pin reset.
    for (i = 0; i < 4; i++) begin
      wr(8'he7, {1'h0, i[0], i[1], 5'h00});
      cmp(reset_request, {7'h00, i[1]});
      rd(8'he7, {1'h0, i[0], 6'h00});
      @(posedge sys_clk);
      nrst <= 1'h0;
      repeat (3) @(posedge sys_clk);
      nrst <= 1'h1;
      #1 cmp(boot_from_loader, {7'h00, i[0] & i[1]});
      rd(8'he1, 8'h00);
    end
    $display("reset test done");
    end_sim;
  end
endmodule // tb
